// File: hdl/uwdp_phy_end.sv
// transceiver end of the wide data port: receive hold and transmit take
`timescale 1ns/1ps
`include "uwdp_map.svh"

module uwdp_phy_end
    import uwdp_pkg::*;
(
    input  wire logic                    mclk_i,
    input  wire logic                    reset_n_i,
    uwdp_if.device                       bus,
    input  wire logic                    rx_sop_i,
    input  wire logic                    rx_eop_i,
    input  wire logic                    rx_err_i,
    input  wire logic                    rx_push_valid_i,
    output logic                         rx_push_ready_o,
    input  wire logic [`UWDP_DATA_W-1:0] rx_push_data_i,
    input  wire logic                    rx_push_high_i,
    output logic      [`UWDP_DATA_W-1:0] tx_data_o,
    output logic      [1:0]              tx_bytes_o,
    output logic                         tx_strobe_o
);

    // =================================================================
    // signals
    uwdp_dev_type                 dev_reg;
    uwdp_dev_type                 dev_next;
    logic                         fifo_in_valid;
    logic                         fifo_in_ready;
    logic [`UWDP_FIFO_W-1:0]      fifo_in_data;
    logic                         fifo_out_valid;
    logic                         fifo_out_ready;
    logic [`UWDP_FIFO_W-1:0]      fifo_out_data;
    logic                         consumed;
    logic                         hold_free;
    logic                         busy;
    logic                         err_set;
    logic                         err_clear;
    logic                         drive_bus;

    // =================================================================
    // receive buffer between the line decoder and the holding register
    // words are only taken while a packet is open
    assign busy            = (dev_reg.state != UWDP_RX_IDLE);
    assign fifo_in_valid   = rx_push_valid_i &
                             (dev_reg.state == UWDP_RX_ACTIVE);
    assign fifo_in_data    = {rx_push_high_i, rx_push_data_i};
    assign rx_push_ready_o = fifo_in_ready &
                             (dev_reg.state == UWDP_RX_ACTIVE);

    uwdp_fifo
    #(
        .WIDTH (`UWDP_FIFO_W),
        .DEPTH (`UWDP_FIFO_DEPTH)
    )
    u_rx_fifo
    (
        .mclk_i      (mclk_i),
        .reset_n_i   (reset_n_i),
        .in_valid_i  (fifo_in_valid),
        .in_ready_o  (fifo_in_ready),
        .in_data_i   (fifo_in_data),
        .out_valid_o (fifo_out_valid),
        .out_ready_i (fifo_out_ready),
        .out_data_o  (fifo_out_data)
    );

    // =================================================================
    // holding register hand-off
    // the sie takes the word in every cycle it is shown, so showing it
    // once while transmit is low empties the register
    assign consumed       = dev_reg.rxvalid & ~bus.txvalid;
    assign hold_free      = ~dev_reg.rxvalid | consumed;
    assign fifo_out_ready = hold_free & busy;

    // error flag lives for the packet; a new error beats the clear
    assign err_set   = rx_err_i & busy;
    // same exit test as the sequencer, kept off dev_next to avoid a loop
    assign err_clear = (dev_reg.state == UWDP_RX_FLUSH) &
                       ~fifo_out_valid & hold_free;

    // =================================================================
    // next state
    always_comb
    begin
        dev_next = dev_reg;
        dev_next.tx_strobe = 1'b0;

        // receive sequencer
        case (dev_reg.state)
            UWDP_RX_IDLE:
            begin
                if (rx_sop_i)
                begin
                    dev_next.state = UWDP_RX_ACTIVE;
                end
            end
            UWDP_RX_ACTIVE:
            begin
                if (rx_eop_i)
                begin
                    dev_next.state = UWDP_RX_FLUSH;
                end
            end
            UWDP_RX_FLUSH:
            begin
                // leave only when nothing is left to hand over
                if (!fifo_out_valid && hold_free)
                begin
                    dev_next.state = UWDP_RX_IDLE;
                end
            end
            default:
            begin
                dev_next.state = UWDP_RX_IDLE;
            end
        endcase
        dev_next.rxactive = (dev_next.state != UWDP_RX_IDLE);

        // holding register; loads only while busy, so valid never
        // appears without active
        if (consumed)
        begin
            dev_next.rxvalid = 1'b0;
        end
        if (fifo_out_valid && fifo_out_ready)
        begin
            dev_next.rxvalid   = 1'b1;
            dev_next.hold_high = bus.wide_mode &
                                 fifo_out_data[`UWDP_FIFO_HI_BIT];
            if (dev_next.hold_high)
            begin
                dev_next.hold_data =
                    fifo_out_data[`UWDP_DATA_W-1:0];
            end
            else
            begin
                dev_next.hold_data =
                    {`UWDP_HI_ZERO, fifo_out_data[`UWDP_LO_MSB:0]};
            end
        end

        // receive error, registered with the data
        if (err_clear)
        begin
            dev_next.rxerror = 1'b0;
        end
        if (err_set)
        begin
            dev_next.rxerror = 1'b1;
        end

        // transmit take: one word per cycle while transmit valid
        if (bus.txvalid)
        begin
            dev_next.tx_strobe = 1'b1;
            if (bus.wide_mode && bus.validh_bus)
            begin
                dev_next.tx_data  = bus.data_bus;
                dev_next.tx_bytes = `UWDP_BYTES_TWO;
            end
            else
            begin
                // the upper byte is not ours to send
                dev_next.tx_data  =
                    {`UWDP_HI_ZERO, bus.data_bus[`UWDP_LO_MSB:0]};
                dev_next.tx_bytes = `UWDP_BYTES_ONE;
            end
        end
    end

    // =================================================================
    // state register
    always_ff @(posedge mclk_i)
    begin
        if (!reset_n_i)
        begin
            dev_reg           <= '0;
            dev_reg.state     <= UWDP_RX_IDLE;
            dev_reg.tx_bytes  <= `UWDP_BYTES_NONE;
        end
        else
        begin
            dev_reg <= dev_next;
        end
    end

    // =================================================================
    // bus drive
    // transmit always wins the direction, so a late transmit request
    // cannot collide with our drive; bus floats when both are low
    assign drive_bus = dev_reg.rxvalid & ~bus.txvalid;

    assign bus.dev_data_oe_n   = ~drive_bus;
    assign bus.dev_data_out    = dev_reg.hold_data;
    assign bus.dev_validh_oe_n = ~(drive_bus & bus.wide_mode);
    assign bus.dev_validh_out  = dev_reg.hold_high;
    assign bus.rxvalid         = dev_reg.rxvalid;
    assign bus.rxactive        = dev_reg.rxactive;
    assign bus.rxerror         = dev_reg.rxerror;

    // =================================================================
    // user side transmit outputs
    assign tx_data_o   = dev_reg.tx_data;
    assign tx_bytes_o  = dev_reg.tx_bytes;
    assign tx_strobe_o = dev_reg.tx_strobe;

endmodule

// File: hdl/uwdp_map.svh
// constants shared by both ends of the wide data port
`ifndef UWDP_MAP_SVH
`define UWDP_MAP_SVH

// =====================================================================
// bus geometry
`define UWDP_DATA_W      16
`define UWDP_BYTE_W      8
`define UWDP_LO_MSB      7
`define UWDP_HI_ZERO     8'h00
`define UWDP_BUS_ZERO    16'h0000

// =====================================================================
// receive buffer
`define UWDP_FIFO_W      17
`define UWDP_FIFO_DEPTH  8
`define UWDP_FIFO_HI_BIT 16

// =====================================================================
// byte counts reported per transfer
`define UWDP_BYTES_NONE  2'h0
`define UWDP_BYTES_ONE   2'h1
`define UWDP_BYTES_TWO   2'h2

`endif

// File: hdl/uwdp_pkg.sv
// types shared by both ends of the wide data port
`include "uwdp_map.svh"

package uwdp_pkg;

    // =================================================================
    // receive sequencer states, one-hot
    typedef enum logic [2:0]
    {
        UWDP_RX_IDLE   = 3'h1,
        UWDP_RX_ACTIVE = 3'h2,
        UWDP_RX_FLUSH  = 3'h4
    } uwdp_rx_state_type;

    // =================================================================
    // device end state
    typedef struct packed {
        uwdp_rx_state_type             state;
        logic                          rxactive;
        logic                          rxvalid;
        logic                          rxerror;
        logic [`UWDP_DATA_W-1:0]       hold_data;
        logic                          hold_high;
        logic [`UWDP_DATA_W-1:0]       tx_data;
        logic [1:0]                    tx_bytes;
        logic                          tx_strobe;
    } uwdp_dev_type;

    // =================================================================
    // sie end state
    typedef struct packed {
        logic                          wide;
        logic                          txvalid;
        logic [`UWDP_DATA_W-1:0]       tx_data;
        logic                          tx_high;
        logic [`UWDP_DATA_W-1:0]       rx_data;
        logic [1:0]                    rx_bytes;
        logic                          rx_strobe;
        logic                          rx_active;
        logic                          rx_error;
        logic                          rx_end;
    } uwdp_sie_type;

endpackage

// File: hdl/uwdp_if.sv
// shared data port between transceiver and serial interface engine
`timescale 1ns/1ps
`include "uwdp_map.svh"

interface uwdp_if;
    import uwdp_pkg::*;

    logic                    wide_mode;
    logic                    txvalid;
    logic                    rxvalid;
    logic                    rxactive;
    logic                    rxerror;
    logic [`UWDP_DATA_W-1:0] dev_data_out;
    logic                    dev_data_oe_n;
    logic                    dev_validh_out;
    logic                    dev_validh_oe_n;
    logic [`UWDP_DATA_W-1:0] sie_data_out;
    logic                    sie_data_oe_n;
    logic                    sie_validh_out;
    logic                    sie_validh_oe_n;
    logic [`UWDP_DATA_W-1:0] data_bus;
    logic                    validh_bus;

    // wire level; pins are pulled down when nobody drives
    assign data_bus   = !dev_data_oe_n ? dev_data_out :
                        !sie_data_oe_n ? sie_data_out : `UWDP_BUS_ZERO;
    assign validh_bus = !dev_validh_oe_n ? dev_validh_out :
                        !sie_validh_oe_n ? sie_validh_out : 1'b0;

    modport device
    (
        input  wide_mode,
        input  txvalid,
        input  data_bus,
        input  validh_bus,
        output rxvalid,
        output rxactive,
        output rxerror,
        output dev_data_out,
        output dev_data_oe_n,
        output dev_validh_out,
        output dev_validh_oe_n
    );

    modport sie
    (
        output wide_mode,
        output txvalid,
        input  data_bus,
        input  validh_bus,
        input  rxvalid,
        input  rxactive,
        input  rxerror,
        output sie_data_out,
        output sie_data_oe_n,
        output sie_validh_out,
        output sie_validh_oe_n
    );

endinterface

// File: hdl/uwdp_fifo.sv
// small flip-flop fifo with valid and ready on both sides
`timescale 1ns/1ps
`include "uwdp_map.svh"

module uwdp_fifo
    import uwdp_pkg::*;
#(
    parameter int WIDTH = `UWDP_FIFO_W,
    parameter int DEPTH = `UWDP_FIFO_DEPTH
)
(
    input  wire logic             mclk_i,
    input  wire logic             reset_n_i,
    input  wire logic             in_valid_i,
    output logic                  in_ready_o,
    input  wire logic [WIDTH-1:0] in_data_i,
    output logic                  out_valid_o,
    input  wire logic             out_ready_i,
    output logic      [WIDTH-1:0] out_data_o
);
    localparam int AW = $clog2(DEPTH);

    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [AW-1:0]               wr_ptr;
        logic [AW-1:0]               rd_ptr;
        logic [AW:0]                 count;
    } uwdp_fifo_type;

    uwdp_fifo_type fifo_reg;
    uwdp_fifo_type fifo_next;
    logic          push;
    logic          pop;

    // =================================================================
    // flags straight from the fill count, so full and empty are exact
    assign in_ready_o  = (fifo_reg.count != (AW+1)'(DEPTH));
    assign out_valid_o = (fifo_reg.count != '0);
    assign out_data_o  = fifo_reg.mem[fifo_reg.rd_ptr];
    assign push        = in_valid_i & in_ready_o;
    assign pop         = out_valid_o & out_ready_i;

    // =================================================================
    // pointer and storage update
    always_comb
    begin
        fifo_next = fifo_reg;
        if (push)
        begin
            fifo_next.mem[fifo_reg.wr_ptr] = in_data_i;
            fifo_next.wr_ptr = AW'(fifo_reg.wr_ptr + 1'b1);
        end
        if (pop)
        begin
            fifo_next.rd_ptr = AW'(fifo_reg.rd_ptr + 1'b1);
        end
        if (push && !pop)
        begin
            fifo_next.count = (AW+1)'(fifo_reg.count + 1'b1);
        end
        else if (pop && !push)
        begin
            fifo_next.count = (AW+1)'(fifo_reg.count - 1'b1);
        end
    end

    always_ff @(posedge mclk_i)
    begin
        if (!reset_n_i)
        begin
            fifo_reg <= '0;
        end
        else
        begin
            fifo_reg <= fifo_next;
        end
    end

endmodule

// File: hdl/uwdp_sie_end.sv
// link controller end of the wide data port
`timescale 1ns/1ps
`include "uwdp_map.svh"

module uwdp_sie_end
    import uwdp_pkg::*;
(
    input  wire logic                    mclk_i,
    input  wire logic                    reset_n_i,
    uwdp_if.sie                          bus,
    input  wire logic                    wide_mode_i,
    input  wire logic                    tx_valid_i,
    output logic                         tx_ready_o,
    input  wire logic [`UWDP_DATA_W-1:0] tx_data_i,
    input  wire logic                    tx_high_i,
    output logic      [`UWDP_DATA_W-1:0] rx_data_o,
    output logic      [1:0]              rx_bytes_o,
    output logic                         rx_strobe_o,
    output logic                         rx_active_o,
    output logic                         rx_error_o,
    output logic                         rx_end_o
);

    uwdp_sie_type sie_reg;
    uwdp_sie_type sie_next;

    // =================================================================
    // no transmit while the transceiver is receiving (half duplex)
    assign tx_ready_o = ~bus.rxactive;

    // =================================================================
    // next state
    always_comb
    begin
        sie_next = sie_reg;
        sie_next.wide      = wide_mode_i;
        sie_next.rx_strobe = 1'b0;
        sie_next.rx_active = bus.rxactive;
        sie_next.rx_error  = bus.rxerror;
        sie_next.rx_end    = sie_reg.rx_active & ~bus.rxactive;

        // transmit word; the transceiver takes one every cycle
        sie_next.txvalid = tx_valid_i & tx_ready_o;
        if (sie_next.txvalid)
        begin
            sie_next.tx_data = tx_data_i;
            sie_next.tx_high = tx_high_i;
        end

        // receive capture on every edge that shows receive valid with transmit valid low
        if (bus.rxvalid && !sie_reg.txvalid)
        begin
            sie_next.rx_strobe = 1'b1;
            if (sie_reg.wide && bus.validh_bus)
            begin
                sie_next.rx_data  = bus.data_bus;
                sie_next.rx_bytes = `UWDP_BYTES_TWO;
            end
            else
            begin
                sie_next.rx_data  =
                    {`UWDP_HI_ZERO, bus.data_bus[`UWDP_LO_MSB:0]};
                sie_next.rx_bytes = `UWDP_BYTES_ONE;
            end
        end
    end

    always_ff @(posedge mclk_i)
    begin
        if (!reset_n_i)
        begin
            sie_reg          <= '0;
            sie_reg.rx_bytes <= `UWDP_BYTES_NONE;
        end
        else
        begin
            sie_reg <= sie_next;
        end
    end

    // =================================================================
    // bus drive, only while transmit valid
    assign bus.wide_mode       = sie_reg.wide;
    assign bus.txvalid         = sie_reg.txvalid;
    assign bus.sie_data_oe_n   = ~sie_reg.txvalid;
    assign bus.sie_data_out    = sie_reg.tx_data;
    assign bus.sie_validh_oe_n = ~(sie_reg.txvalid & sie_reg.wide);
    assign bus.sie_validh_out  = sie_reg.tx_high;

    assign rx_data_o   = sie_reg.rx_data;
    assign rx_bytes_o  = sie_reg.rx_bytes;
    assign rx_strobe_o = sie_reg.rx_strobe;
    assign rx_active_o = sie_reg.rx_active;
    assign rx_error_o  = sie_reg.rx_error;
    assign rx_end_o    = sie_reg.rx_end;

endmodule

// File: tb/uwdp_sva.sv
// concurrent checks on the wires between the two port ends
`timescale 1ns/1ps
`include "uwdp_map.svh"

module uwdp_sva
(
    input wire logic                    mclk_i,
    input wire logic                    reset_n_i,
    input wire logic                    wide_mode,
    input wire logic                    txvalid,
    input wire logic                    rxvalid,
    input wire logic                    rxactive,
    input wire logic                    rxerror,
    input wire logic [`UWDP_DATA_W-1:0] dev_data_out,
    input wire logic                    dev_data_oe_n,
    input wire logic                    dev_validh_oe_n,
    input wire logic [`UWDP_DATA_W-1:0] sie_data_out,
    input wire logic                    sie_data_oe_n,
    input wire logic                    sie_validh_oe_n,
    input wire logic [`UWDP_DATA_W-1:0] data_bus,
    input wire logic                    validh_bus
);
    // =================================================================
    // one clock domain; nothing is judged while reset is held
    default clocking dclk @(posedge mclk_i);
    endclocking
    default disable iff (!reset_n_i);

    // device shows a word: receive valid with the bus turned outward
    sequence rx_show_s;
        rxvalid && !txvalid;
    endsequence
    // holding register cannot be full in the first two active cycles
    sequence rx_warmup_s;
        !rxvalid [*2];
    endsequence

    // =================================================================
    // bus direction and qualifiers
    bus_turn_a:
        assert property (txvalid |-> dev_data_oe_n && !sie_data_oe_n
                         && data_bus == sie_data_out)
        else $error("device drove the bus during transmit");
    dev_drive_a:
        assert property (dev_data_oe_n == !(rxvalid && !txvalid))
        else $error("device data drive does not follow the valids");
    rx_bus_a:
        assert property (rx_show_s |-> data_bus == dev_data_out)
        else $error("bus does not carry the held word");
    hi_drive_a:
        assert property (dev_validh_oe_n
                         == !(rxvalid && !txvalid && wide_mode))
        else $error("device qualifier drive is wrong");
    tx_qual_a:
        assert property (sie_validh_oe_n == !(txvalid && wide_mode))
        else $error("link qualifier drive is wrong");
    lo_only_a:
        assert property ((rx_show_s and !validh_bus)
                         |-> data_bus[15:8] == `UWDP_HI_ZERO)
        else $error("upper byte not cleared for a low byte word");

    // =================================================================
    // receive status
    valid_active_a:
        assert property (rxvalid |-> rxactive)
        else $error("receive valid without receive active");
    rx_start_a:
        assert property ($rose(rxactive) |-> rx_warmup_s)
        else $error("receive valid too soon after packet start");
    err_hold_a:
        assert property ($fell(rxerror) |-> $fell(rxactive))
        else $error("receive error cleared while packet busy");
    tx_gap_a:
        assert property ($rose(txvalid) |-> !$past(rxactive))
        else $error("transmit started during a receive packet");
endmodule

// File: tb/uwdp_tb_top.sv
// self-checking bench: both ends of the wide data port back to back
`timescale 1ns/1ps
`include "uwdp_map.svh"

module uwdp_tb_top;
    typedef struct packed {
        logic        w;
        logic        h;
        logic [15:0] d;
        logic [17:0] e;
    } uwdp_row_type;

    logic        mclk_i, reset_n_i, rx_sop_i, rx_eop_i, rx_err_i;
    logic        push_valid, push_ready, push_high, tx_strobe_o;
    logic        wide_mode_i, tx_valid_i, tx_ready_o, tx_high_i;
    logic        rx_strobe_o, rx_active_o, rx_error_o, rx_end_o, err_seen;
    logic [15:0] push_data, tx_data_o, tx_data_i, rx_data_o;
    logic [1:0]  tx_bytes_o, rx_bytes_o;
    logic [17:0] got_q[$], exp_q[$];
    int          num_errors = 0, comparisons = 0, n;
    // wide with both bytes, then the three low byte only cases
    uwdp_row_type rows [4] = '{
        '{1'h1, 1'h1, 16'ha55a, {2'h2, 16'ha55a}},
        '{1'h1, 1'h0, 16'h3cc3, {2'h1, 16'h00c3}},
        '{1'h0, 1'h1, 16'hf00f, {2'h1, 16'h000f}},
        '{1'h0, 1'h0, 16'h8001, {2'h1, 16'h0001}}};

    // =================================================================
    // the two ends, their shared wires and the wire checker
    uwdp_if bus_if ();
    uwdp_phy_end i_uwdp_phy_end (.mclk_i(mclk_i), .reset_n_i(reset_n_i),
        .bus(bus_if), .rx_sop_i(rx_sop_i), .rx_eop_i(rx_eop_i),
        .rx_err_i(rx_err_i), .rx_push_valid_i(push_valid),
        .rx_push_ready_o(push_ready), .rx_push_data_i(push_data),
        .rx_push_high_i(push_high), .tx_data_o(tx_data_o),
        .tx_bytes_o(tx_bytes_o), .tx_strobe_o(tx_strobe_o));
    uwdp_sie_end i_uwdp_sie_end (.mclk_i(mclk_i), .reset_n_i(reset_n_i),
        .bus(bus_if), .wide_mode_i(wide_mode_i), .tx_valid_i(tx_valid_i),
        .tx_ready_o(tx_ready_o), .tx_data_i(tx_data_i),
        .tx_high_i(tx_high_i), .rx_data_o(rx_data_o),
        .rx_bytes_o(rx_bytes_o), .rx_strobe_o(rx_strobe_o),
        .rx_active_o(rx_active_o), .rx_error_o(rx_error_o),
        .rx_end_o(rx_end_o));
    uwdp_sva i_uwdp_sva (.mclk_i(mclk_i), .reset_n_i(reset_n_i),
        .wide_mode(bus_if.wide_mode), .txvalid(bus_if.txvalid),
        .rxvalid(bus_if.rxvalid), .rxactive(bus_if.rxactive),
        .rxerror(bus_if.rxerror), .dev_data_out(bus_if.dev_data_out),
        .dev_data_oe_n(bus_if.dev_data_oe_n),
        .dev_validh_oe_n(bus_if.dev_validh_oe_n),
        .sie_data_out(bus_if.sie_data_out),
        .sie_data_oe_n(bus_if.sie_data_oe_n),
        .sie_validh_oe_n(bus_if.sie_validh_oe_n),
        .data_bus(bus_if.data_bus), .validh_bus(bus_if.validh_bus));

    // =================================================================
    // clock, collector, watchdog
    initial
    begin
        mclk_i = 1'h0;
        forever #12.5 mclk_i = ~mclk_i;
    end
    // words handed up by the link end, one per strobe
    always @(posedge mclk_i)
    begin
        if (rx_strobe_o === 1'h1)
            got_q.push_back({rx_bytes_o, rx_data_o});
        if (rx_error_o === 1'h1)
            err_seen = 1'h1;
    end
    // whole run is well under a thousand cycles
    initial
    begin
        repeat (3000) @(posedge mclk_i);
        num_errors++;
        end_sim();
    end

    // =================================================================
    // tasks
    task automatic chk(input logic [17:0] seen, input logic [17:0] exp);
        comparisons++;
        if (seen !== exp)
        begin
            num_errors++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    // bounded wait for a pulse; sampled once the edge has landed
    task automatic wait_sig(input int sel);
        int   k;
        logic s;
        k = 0;
        do
        begin
            @(posedge mclk_i);
            #1;
            s = (sel == 0) ? tx_strobe_o : rx_end_o;
            k++;
        end
        while (s !== 1'h1 && k < 40);
        chk(18'(s), 18'h1);
    endtask
    task automatic tx_word(input uwdp_row_type r);
        @(negedge mclk_i);
        tx_valid_i = 1'h1;
        tx_high_i = r.h;
        tx_data_i = r.d;
        @(negedge mclk_i);
        tx_valid_i = 1'h0;
        wait_sig(0);
        chk({tx_bytes_o, tx_data_o}, r.e);
    endtask
    task automatic rx_start();
        @(negedge mclk_i);
        rx_sop_i = 1'h1;
        @(negedge mclk_i);
        rx_sop_i = 1'h0;
    endtask
    // valid stays up after acceptance so pushes run back to back
    task automatic push(input logic h, input logic [15:0] d,
                        input logic e);
        int k;
        @(negedge mclk_i);
        push_valid = 1'h1;
        push_high = h;
        push_data = d;
        rx_err_i = e;
        for (k = 0; k < 40 && push_ready !== 1'h1; k++)
            @(negedge mclk_i);
        chk(18'(push_ready), 18'h1);
        chk(18'(rx_active_o), 18'h1);
        @(posedge mclk_i);
        exp_q.push_back((wide_mode_i & h) ? {2'h2, d}
                                          : {2'h1, 8'h00, d[7:0]});
    endtask
    task automatic rx_finish();
        @(negedge mclk_i);
        push_valid = 1'h0;
        rx_err_i = 1'h0;
        rx_eop_i = 1'h1;
        @(negedge mclk_i);
        rx_eop_i = 1'h0;
        wait_sig(1);
        repeat (2) @(posedge mclk_i);
        chk(18'(got_q.size()), 18'(exp_q.size()));
        while (got_q.size() > 0 && exp_q.size() > 0)
            chk(got_q.pop_front(), exp_q.pop_front());
    endtask
    task automatic end_sim();
        $display("num_errors=%0d comparisons=%0d", num_errors, comparisons);
        if (num_errors == 0 && comparisons > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    // =================================================================
    // main sequence
    initial
    begin
        {rx_sop_i, rx_eop_i, rx_err_i, push_valid, push_high} = 5'h0;
        {wide_mode_i, tx_valid_i, tx_high_i, err_seen} = 4'h0;
        {push_data, tx_data_i} = 32'h0;
        reset_n_i = 1'h0;
        repeat (3) @(posedge mclk_i);
        @(negedge mclk_i);
        reset_n_i = 1'h1;
        @(posedge mclk_i);
        #1;
        chk(18'({bus_if.dev_data_oe_n, bus_if.sie_data_oe_n,
                 bus_if.dev_validh_oe_n, bus_if.sie_validh_oe_n,
                 bus_if.rxactive, bus_if.rxvalid, bus_if.txvalid}),
            18'h78);
        chk(18'(push_ready), 18'h0);
        // ordinary cases: one transmit and one receive word per row
        foreach (rows[i])
        begin
            @(negedge mclk_i);
            wide_mode_i = rows[i].w;
            tx_word(rows[i]);
            rx_start();
            push(rows[i].h, rows[i].d, 1'h0);
            rx_finish();
        end
        // long wide packet, refused transmit, error in mid packet
        err_seen = 1'h0;
        rx_start();
        @(negedge mclk_i);
        tx_valid_i = 1'h1;
        wide_mode_i = 1'h1;
        repeat (2) @(negedge mclk_i);
        chk(18'({tx_ready_o, bus_if.txvalid}), 18'h0);
        tx_valid_i = 1'h0;
        for (n = 0; n < 12; n++)
            push(n[0], 16'(n) * 16'h1357 + 16'h2468, n == 5);
        rx_finish();
        chk(18'({err_seen, bus_if.rxerror}), 18'h2);
        // reset in the middle of a packet returns both ends to idle
        rx_start();
        push(1'h1, 16'hbeef, 1'h0);
        @(negedge mclk_i);
        reset_n_i = 1'h0;
        push_valid = 1'h0;
        repeat (3) @(negedge mclk_i);
        reset_n_i = 1'h1;
        @(posedge mclk_i);
        #1;
        chk(18'({bus_if.dev_data_oe_n, bus_if.sie_data_oe_n,
                 bus_if.rxactive, bus_if.rxvalid, bus_if.rxerror}),
            18'h18);
        end_sim();
    end
endmodule
